/* File: logic/ias_audio_port.sv */
// serial digital-audio port with a classic Wishbone register slave
// assumes pins from another domain; link clock is sampled by clk_i
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ns
`include "ias_regs.svh"

module ias_audio_port (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            ce_i,
  input  ias_pkg::ias_wb_req_t wb_i,
  output ias_pkg::ias_wb_rsp_t wb_o,
  input  ias_pkg::ias_pin_in_t pin_i,
  output ias_pkg::ias_pin_out_t pin_o,
  output logic                 rx_irq_o,
  output logic                 tx_irq_o,
  output logic                 shared_irq_o,
  output logic [31:0]          dma_trig_o
);
  import ias_pkg::*;

  ias_state_t  s_reg;
  ias_state_t  s_next;
  logic [15:0] law_lin;
  logic [7:0]  law_code;
  logic [15:0] law_exp;
  logic        en;
  logic        master;
  logic        sck_lvl;
  logic        ws_lvl;
  logic        rise;
  logic        fall;
  logic        acc;
  logic        wr;
  logic        rd;
  logic [5:0]  idx;
  logic [7:0]  wd;
  logic [7:0]  rmux;
  logic [15:0] word;
  logic [4:0]  mbit_nx;

  // compressor sees the rx word in service, the written pair otherwise
  assign law_lin = en ? s_reg.rx_buf : {wb_i.dat[7:0], s_reg.dat_lo};

  ias_ulaw u_law (
    .lin_i  (law_lin),
    .code_i (wb_i.dat[7:0]),
    .code_o (law_code),
    .lin_o  (law_exp)
  );

  assign en     = s_reg.cfg[`IAS_CFG_EN];
  assign master = s_reg.cfg[`IAS_CFG_MASTER];
  assign idx    = wb_i.adr[7:2];
  assign wd     = wb_i.dat[7:0];

  always_comb begin
    unique case (idx)
      `IAS_ADR_CFG:    rmux = s_reg.cfg;
      `IAS_ADR_STAT:   rmux = {2'h0, s_reg.rxlr, s_reg.tx_channel_side_flag, s_reg.ovf,
                               s_reg.unf, s_reg.txc, s_reg.rxc};
      `IAS_ADR_DATL:   rmux = s_reg.rx_dat[7:0];
      `IAS_ADR_DATH:   rmux = s_reg.rx_dat[15:8];
      `IAS_ADR_CLKDIV: rmux = s_reg.clkdiv;
      `IAS_ADR_WORDS:  rmux = {3'h0, s_reg.words};
      `IAS_ADR_SYSIRQ: rmux = {4'h0, s_reg.sys};
      default:         rmux = 8'h00;
    endcase
  end

  always_comb begin
    s_next  = s_reg;
    sck_lvl = 1'b0;
    ws_lvl  = 1'b0;
    rise    = 1'b0;
    fall    = 1'b0;
    acc     = 1'b0;
    wr      = 1'b0;
    rd      = 1'b0;
    word    = 16'h0000;
    mbit_nx = 5'h00;
    if (ce_i) begin
      s_next.ack    = 1'b0;
      s_next.rx_dma = 1'b0;
      s_next.tx_dma = 1'b0;

      // two-stage synchronisers for clock, word select and data in
      s_next.s1 = {pin_i.sck, pin_i.ws, pin_i.sd};
      s_next.s2 = s_reg.s1;

      // register slave: one wait state, unmapped reads give zero
      acc = wb_i.cyc & wb_i.stb & ~s_reg.ack;
      wr  = acc & wb_i.we & wb_i.sel[0];
      rd  = acc & ~wb_i.we;
      s_next.ack = acc;
      if (rd) begin
        s_next.rdata = rmux;
      end
      if (wr) begin
        unique case (idx)
          `IAS_ADR_CFG:    s_next.cfg = wd;
          `IAS_ADR_STAT: begin
            s_next.rxc = wd[`IAS_STAT_RXC];
            s_next.txc = wd[`IAS_STAT_TXC];
            s_next.unf = wd[`IAS_STAT_UNF];
            s_next.ovf = wd[`IAS_STAT_OVF];
          end
          `IAS_ADR_DATL:   s_next.dat_lo = wd;
          `IAS_ADR_DATH: begin
            if (en) begin
              s_next.tx_hold = s_reg.cfg[`IAS_CFG_EXPAND] ?
                               law_exp : {wd, s_reg.dat_lo};
              s_next.hold_full = 1'b1;
              s_next.txc = 1'b0;
            end else begin
              // stand-alone codec: result lands in the read pair
              if (s_reg.cfg[`IAS_CFG_EXPAND]) begin
                s_next.rx_dat = law_exp;
              end else if (s_reg.cfg[`IAS_CFG_COMPRESS]) begin
                s_next.rx_dat = {law_code, 8'h00};
              end else begin
                s_next.rx_dat = {wd, s_reg.dat_lo};
              end
            end
          end
          `IAS_ADR_CLKDIV: s_next.clkdiv = wd;
          `IAS_ADR_WORDS:  s_next.words = wd[4:0];
          `IAS_ADR_SYSIRQ: s_next.sys = wd[3:0];
          default: ;
        endcase
      end
      if (rd && idx == `IAS_ADR_DATH) begin
        s_next.rx_dat_valid = 1'b0;
        s_next.rxc = 1'b0;
      end

      // master clock and word select generator
      if (en && master) begin
        if (s_reg.mdiv >= s_reg.clkdiv) begin
          s_next.mdiv = 8'h00;
          s_next.msck = ~s_reg.msck;
          if (s_reg.msck) begin
            mbit_nx = (s_reg.mbit == s_reg.words) ? 5'h00 :
                      5'(s_reg.mbit + 5'h01);
            s_next.mbit = mbit_nx;
            if (mbit_nx == s_reg.words) begin
              s_next.mws = ~s_reg.mws;
            end
          end
        end else begin
          s_next.mdiv = 8'(s_reg.mdiv + 8'h01);
        end
      end else begin
        s_next.mdiv = 8'h00;
        s_next.msck = 1'b0;
        s_next.mbit = 5'h00;
      end

      sck_lvl = master ? s_reg.msck : s_reg.s2[2];
      ws_lvl  = master ? s_reg.mws : s_reg.s2[1];
      s_next.sck_prev = sck_lvl;
      rise = en & sck_lvl & ~s_reg.sck_prev;
      fall = en & ~sck_lvl & s_reg.sck_prev;

      // rx buffer to readable pair; done before new words arrive
      if (en && s_reg.rx_buf_full && !s_reg.rx_dat_valid) begin
        s_next.rx_dat = s_reg.cfg[`IAS_CFG_COMPRESS] ?
                        {law_code, 8'h00} : s_reg.rx_buf;
        s_next.rx_dat_valid = 1'b1;
        s_next.rx_buf_full = 1'b0;
        s_next.rxlr = s_reg.rx_buf_side;
        s_next.rxc = 1'b1;
        s_next.sys[`IAS_SYS_RXF] = 1'b1;
        s_next.rx_dma = 1'b1;
      end

      // tx holding pair to internal buffer
      if (en && !s_reg.tx_buf_full && s_reg.hold_full) begin
        s_next.tx_buf = s_reg.tx_hold;
        s_next.tx_buf_full = 1'b1;
        s_next.hold_full = 1'b0;
        s_next.txc = 1'b1;
        s_next.sys[`IAS_SYS_TXF] = 1'b1;
        s_next.tx_dma = 1'b1;
        if (!s_reg.cfg[`IAS_CFG_TX_SINGLE_CHANNEL]) begin
          s_next.tx_channel_side_flag = ~s_reg.tx_channel_side_flag;
        end
      end

      if (rise) begin
        s_next.ws_prev = ws_lvl;
        // bits past 16 are dropped
        if (s_reg.rx_cnt != `IAS_DATA_BITS) begin
          s_next.rx_sh = {s_reg.rx_sh[14:0], s_reg.s2[0]};
          s_next.rx_cnt = 5'(s_reg.rx_cnt + 5'h01);
        end
        if (ws_lvl != s_reg.ws_prev) begin
          // this bit was the last one of the word on the old channel
          word = 16'(s_next.rx_sh << 5'(`IAS_DATA_BITS - s_next.rx_cnt));
          s_next.rx_cnt = 5'h00;
          if (!(s_reg.cfg[`IAS_CFG_RXMONO] && s_reg.ws_prev)) begin
            if (s_next.rx_buf_full) begin
              s_next.ovf = 1'b1;
            end
            s_next.rx_buf = word;
            s_next.rx_buf_full = 1'b1;
            s_next.rx_buf_side = s_reg.ws_prev;
          end
          // next word: stale contents are resent when empty
          s_next.tx_sh = s_reg.tx_buf;
          if (!s_reg.tx_buf_full) begin
            s_next.unf = 1'b1;
          end else if (!s_reg.cfg[`IAS_CFG_TX_SINGLE_CHANNEL] || ws_lvl) begin
            s_next.tx_buf_full = 1'b0;
          end
        end
      end

      if (fall) begin
        // zero fill pads words longer than 16 bits
        s_next.sd_out = s_reg.tx_sh[15];
        s_next.tx_sh = {s_reg.tx_sh[14:0], 1'b0};
      end

      if (!en) begin
        // track idle word select so enabling gives no false word end
        s_next.ws_prev = ws_lvl;
        s_next.rx_cnt = 5'h00;
        s_next.sd_out = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg        <= '0;
      s_reg.clkdiv <= `IAS_CLKDIV_RST;
      s_reg.words  <= `IAS_WORDS_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_o.ack     = s_reg.ack;
  assign wb_o.dat     = {24'h000000, s_reg.rdata};
  assign pin_o.sck    = s_reg.msck;
  assign pin_o.sck_oe = en & master;
  assign pin_o.ws     = s_reg.mws;
  assign pin_o.ws_oe  = en & master;
  assign pin_o.sd     = s_reg.sd_out;

  assign rx_irq_o = s_reg.rxc & s_reg.cfg[`IAS_CFG_RXIE] &
                    s_reg.sys[`IAS_SYS_RXE];
  assign tx_irq_o = s_reg.txc & s_reg.cfg[`IAS_CFG_TXIE] &
                    s_reg.sys[`IAS_SYS_TXE];
  // the handler must poll both the rx and the tx flags behind this line
  assign shared_irq_o = rx_irq_o | tx_irq_o;

  always_comb begin
    dma_trig_o = 32'h00000000;
    dma_trig_o[`IAS_DMA_RX_NUM] = s_reg.rx_dma;
    dma_trig_o[`IAS_DMA_TX_NUM] = s_reg.tx_dma;
  end

endmodule // ias_audio_port

/* File: logic/ias_regs.svh */
// register map, field positions, reset values and fixed numbers
// of the serial audio port; included by the port, the codec, the checker and the bench
`ifndef IAS_REGS_SVH
`define IAS_REGS_SVH

`define IAS_ADR_CFG       6'h00
`define IAS_ADR_STAT      6'h01
`define IAS_ADR_DATL      6'h02
`define IAS_ADR_DATH      6'h03
`define IAS_ADR_CLKDIV    6'h04
`define IAS_ADR_WORDS     6'h05
`define IAS_ADR_SYSIRQ    6'h06

`define IAS_CFG_EN        3'h0
`define IAS_CFG_MASTER    3'h1
`define IAS_CFG_TX_SINGLE_CHANNEL    3'h2
`define IAS_CFG_RXMONO    3'h3
`define IAS_CFG_RXIE      3'h4
`define IAS_CFG_TXIE      3'h5
`define IAS_CFG_EXPAND    3'h6
`define IAS_CFG_COMPRESS  3'h7

`define IAS_STAT_RXC      3'h0
`define IAS_STAT_TXC      3'h1
`define IAS_STAT_UNF      3'h2
`define IAS_STAT_OVF      3'h3
`define IAS_STAT_TX_CHANNEL_SIDE_FLAG     3'h4
`define IAS_STAT_RXLR     3'h5

`define IAS_SYS_RXF       2'h0
`define IAS_SYS_TXF       2'h1
`define IAS_SYS_RXE       2'h2
`define IAS_SYS_TXE       2'h3

`define IAS_CLKDIV_RST    8'h04
`define IAS_WORDS_RST     5'h0F
`define IAS_DATA_BITS     5'h10

`define IAS_DMA_RX_NUM    5'h1B
`define IAS_DMA_TX_NUM    5'h1C

`define IAS_LAW_BIAS      16'h0084
`define IAS_LAW_CLIP      16'h7F7B

`endif

/* File: logic/ias_pkg.sv */
// types of the serial audio port: bus carriers, pin carriers, state
// assumes ias_regs.svh is on the include path
package ias_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ias_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } ias_wb_rsp_t;

  typedef struct packed {
    logic sck;
    logic ws;
    logic sd;
  } ias_pin_in_t;

  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic ws;
    logic ws_oe;
    logic sd;
  } ias_pin_out_t;

  typedef struct packed {
    logic        ack;
    logic [7:0]  rdata;
    logic [7:0]  cfg;
    logic        rxc;
    logic        txc;
    logic        unf;
    logic        ovf;
    logic        tx_channel_side_flag;
    logic        rxlr;
    logic [3:0]  sys;
    logic [7:0]  clkdiv;
    logic [4:0]  words;
    logic [7:0]  dat_lo;
    logic [15:0] tx_hold;
    logic        hold_full;
    logic [15:0] tx_buf;
    logic        tx_buf_full;
    logic [15:0] tx_sh;
    logic        sd_out;
    logic [15:0] rx_sh;
    logic [4:0]  rx_cnt;
    logic [15:0] rx_buf;
    logic        rx_buf_full;
    logic        rx_buf_side;
    logic [15:0] rx_dat;
    logic        rx_dat_valid;
    logic [2:0]  s1;
    logic [2:0]  s2;
    logic        sck_prev;
    logic        ws_prev;
    logic [7:0]  mdiv;
    logic        msck;
    logic        mws;
    logic [4:0]  mbit;
    logic        rx_dma;
    logic        tx_dma;
  } ias_state_t;

endpackage

/* File: logic/ias_ulaw.sv */
// mu-law compressor (16-bit linear to 8-bit code) and expander
// purely combinational; the port registers whatever it uses
`timescale 1ns/1ns
`include "ias_regs.svh"

module ias_ulaw (
  input  wire logic [15:0] lin_i,
  input  wire logic [7:0]  code_i,
  output logic      [7:0]  code_o,
  output logic      [15:0] lin_o
);

  always_comb begin
    logic        sgn;
    logic [15:0] mag;
    logic [2:0]  ex;
    logic [3:0]  man;
    sgn = lin_i[15];
    mag = sgn ? 16'(~lin_i + 16'h0001) : lin_i;
    ex  = 3'h0;
    // clipping keeps the biased magnitude inside 15 bits
    if (mag > `IAS_LAW_CLIP) begin
      mag = `IAS_LAW_CLIP;
    end
    mag = 16'(mag + `IAS_LAW_BIAS);
    for (int i = 0; i < 8; i++) begin
      if (mag[i + 7]) begin
        ex = 3'(i);
      end
    end
    man    = 4'(mag >> ({1'b0, ex} + 4'h3));
    code_o = ~{sgn, ex, man};
  end

  always_comb begin
    logic [7:0]  u;
    logic [15:0] m;
    u = ~code_i;
    m = 16'((({12'h000, u[3:0]} << 3) + `IAS_LAW_BIAS) << u[6:4]);
    m = 16'(m - `IAS_LAW_BIAS);
    lin_o = u[7] ? 16'(~m + 16'h0001) : m;
  end

endmodule // ias_ulaw

/* File: testbench/ias_audio_port_assertions.sv */
// checker of the serial audio port, watching the top ports only
// assumes ce_i stays high and the clock divider keeps its reset value
`timescale 1ns/1ns
`include "ias_regs.svh"

module ias_audio_port_assertions (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  ias_pkg::ias_wb_req_t  wb_i,
  input  ias_pkg::ias_wb_rsp_t  wb_o,
  input  ias_pkg::ias_pin_out_t pin_o,
  input  wire logic             rx_irq_o,
  input  wire logic             tx_irq_o,
  input  wire logic             shared_irq_o,
  input  wire logic [31:0]      dma_trig_o
);
  import ias_pkg::*;
  logic [7:0] cfg_reg;
  logic       take;
  assign take = wb_i.cyc & wb_i.stb & ~wb_o.ack & ce_i;
  // shadow of the config byte, so enables can be judged from the ports
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= 8'h00;
    end else if (take & wb_i.we & wb_i.sel[0]
                 & (wb_i.adr[7:2] == `IAS_ADR_CFG)) begin
      cfg_reg <= wb_i.dat[7:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next;
    take |=> wb_o.ack ##1 !wb_o.ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("bad ack timing");
  property p_dma_bits;
    (dma_trig_o & ~((32'h1 << `IAS_DMA_RX_NUM)
                   | (32'h1 << `IAS_DMA_TX_NUM))) == 32'h0;
  endproperty
  a_dma_bits: assert property (p_dma_bits) else $error("stray dma bit");
  property p_dma_pulse;
    dma_trig_o[`IAS_DMA_TX_NUM] |=> !dma_trig_o[`IAS_DMA_TX_NUM];
  endproperty
  a_dma_pulse: assert property (p_dma_pulse) else $error("long dma");
  property p_shared;
    shared_irq_o == (rx_irq_o | tx_irq_o);
  endproperty
  a_shared: assert property (p_shared) else $error("shared irq wrong");
  property p_tx_en;
    tx_irq_o |-> cfg_reg[`IAS_CFG_TXIE];
  endproperty
  a_tx_en: assert property (p_tx_en) else $error("tx irq unmasked");
  property p_rx_en;
    rx_irq_o |-> cfg_reg[`IAS_CFG_RXIE];
  endproperty
  a_rx_en: assert property (p_rx_en) else $error("rx irq unmasked");
  property p_quiet;
    (!cfg_reg[`IAS_CFG_EN]) [*2] |-> !pin_o.sd && !pin_o.sck_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("link active off");
  property p_master_oe;
    pin_o.sck_oe == (cfg_reg[`IAS_CFG_EN] & cfg_reg[`IAS_CFG_MASTER])
      && pin_o.ws_oe == pin_o.sck_oe;
  endproperty
  a_master_oe: assert property (p_master_oe) else $error("bad enables");
  property p_half;
    $rose(pin_o.sck) && pin_o.sck_oe |-> pin_o.sck [*5] ##1 !pin_o.sck;
  endproperty
  a_half: assert property (p_half) else $error("bad sck half period");
  c_rx: cover property (dma_trig_o[`IAS_DMA_RX_NUM]);
  c_tx: cover property (dma_trig_o[`IAS_DMA_TX_NUM]);
  c_ms: cover property ($rose(pin_o.sck) && pin_o.sck_oe);
endmodule // ias_audio_port_assertions

bind ias_audio_port ias_audio_port_assertions u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb_i), .wb_o(wb_o),
  .pin_o(pin_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o),
  .shared_irq_o(shared_irq_o), .dma_trig_o(dma_trig_o));

/* File: testbench/ias_codec_model.sv */
// outside audio master: serial clock, word select, serial data
// assumes sck_i is the resolved wire clock that both parties see
`timescale 1ns/1ns

module ias_codec_model (
  input  wire logic             run_i,
  input  wire logic             sck_i,
  input  wire logic             sd_i,
  input  wire logic [1:0][15:0] tx_i,
  output logic                  sck_o,
  output logic                  ws_o,
  output logic                  sd_o,
  output logic      [1:0][15:0] got_o
);
  int          bi = 1;
  logic        ch = 1'b1;
  logic [15:0] cap = 16'h0;
  initial begin
    sck_o = 1'b0;
    ws_o = 1'b1;
    sd_o = 1'b0;
    got_o = '0;
    #7;
    forever begin
      #80;
      // clock stands still while run_i is low; an idle data line wanders
      if (run_i) sck_o = ~sck_o;
      else sd_o = ~sd_o;
    end
  end
  always @(negedge sck_i) begin
    cap = {cap[14:0], sd_i};
    if (bi == 0) begin
      got_o[ch] = cap;
      ch = ~ch;
      bi = 15;
    end else begin
      bi = bi - 1;
    end
    sd_o = tx_i[ch][bi];
    ws_o = (bi == 0) ? ~ch : ch;
  end
endmodule // ias_codec_model

/* File: testbench/ias_audio_port_tb.sv */
// self-checking bench of the serial audio port with an outside master
// assumes the link model and the bound checker beside the port
`timescale 1ns/1ns
`include "ias_regs.svh"

module ias_audio_port_tb;
  import ias_pkg::*;
  localparam logic [7:0] A_CFG = {`IAS_ADR_CFG, 2'b00};
  localparam logic [7:0] A_ST = {`IAS_ADR_STAT, 2'b00};
  localparam logic [7:0] A_DL = {`IAS_ADR_DATL, 2'b00};
  localparam logic [7:0] A_DH = {`IAS_ADR_DATH, 2'b00};
  localparam logic [7:0] A_SYS = {`IAS_ADR_SYSIRQ, 2'b00};
  logic             clk_i;
  logic             rst_i;
  ias_wb_req_t      wb_i;
  ias_wb_rsp_t      wb_o;
  ias_pin_in_t      pin_i;
  ias_pin_out_t     pin_o;
  logic             rx_irq_o;
  logic             tx_irq_o;
  logic             shared_irq_o;
  logic [31:0]      dma_trig_o;
  logic             run;
  logic             m_sck;
  logic             m_ws;
  logic             m_sd;
  logic [1:0][15:0] m_tx;
  logic [1:0][15:0] m_got;
  logic [7:0]       q;
  int               errors = 0;
  int               checks_done = 0;
  int               n_tx = 0;
  assign pin_i = '{sck: pin_o.sck_oe ? pin_o.sck : m_sck,
                   ws: pin_o.ws_oe ? pin_o.ws : m_ws, sd: m_sd};
  ias_audio_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_i(wb_i), .wb_o(wb_o), .pin_i(pin_i), .pin_o(pin_o),
    .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o),
    .shared_irq_o(shared_irq_o), .dma_trig_o(dma_trig_o));
  ias_codec_model mdl_u (.run_i(run), .sck_i(pin_i.sck), .sd_i(pin_o.sd),
    .tx_i(m_tx), .sck_o(m_sck), .ws_o(m_ws), .sd_o(m_sd), .got_o(m_got));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (dma_trig_o[`IAS_DMA_TX_NUM] === 1'b1) n_tx++;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1,
              dat: {24'h0, d}};
    @(posedge clk_i);
    while (wb_o.ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) cmp(16'h0, 16'h1);
    q = wb_o.dat[7:0];
    wb_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    cmp({8'h0, q}, {8'h0, e});
  endtask
  task automatic wait_got(input int c, input logic [15:0] w);
    int n;
    n = 0;
    while (m_got[c] !== w && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    cmp(m_got[c], w);
  endtask
  task automatic t_engine();
    rd(A_CFG, 8'h00);
    rd({`IAS_ADR_CLKDIV, 2'b00}, `IAS_CLKDIV_RST);
    rd(8'h1C, 8'h00);
    bus(A_CFG, 1'b1, 8'h40);
    bus(A_DH, 1'b1, 8'h00);
    // code 00 expands to -((((15 << 3) + 132) << 7) - 132)
    rd(A_DL, 8'h84);
    rd(A_DH, 8'h82);
    rd(A_ST, 8'h00);
    cmp(16'(n_tx), 16'h0);
    $display("test engine done");
  endtask
  task automatic t_slave();
    logic [7:0] s;
    logic [7:0] l;
    bus(A_SYS, 1'b1, 8'h0C);
    bus(A_CFG, 1'b1, 8'h01);
    bus(A_DL, 1'b1, 8'hA5);
    bus(A_DH, 1'b1, 8'h3C);
    rd(A_ST, 8'h12);
    rd(A_SYS, 8'h0E);
    cmp(16'(n_tx), 16'h1);
    cmp({15'h0, tx_irq_o}, 16'h0);
    bus(A_CFG, 1'b1, 8'h21);
    cmp({15'h0, tx_irq_o}, 16'h1);
    bus(A_DL, 1'b1, 8'hC3);
    bus(A_DH, 1'b1, 8'h5A);
    cmp({15'h0, tx_irq_o}, 16'h0);
    m_tx = {16'h64CE, 16'h9B31};
    run = 1'b1;
    wait_got(0, 16'h3CA5);
    wait_got(1, 16'h5AC3);
    wait_got(0, 16'h5AC3);
    run = 1'b0;
    bus(A_ST, 1'b0, 8'h00);
    cmp({8'h0, q & 8'h0D}, 16'h000D);
    cmp({15'h0, rx_irq_o}, 16'h0);
    bus(A_DH, 1'b0, 8'h00);
    bus(A_ST, 1'b0, 8'h00);
    s = q;
    bus(A_DL, 1'b0, 8'h00);
    l = q;
    bus(A_DH, 1'b0, 8'h00);
    cmp({q, l}, s[5] ? 16'h64CE : 16'h9B31);
    bus(A_ST, 1'b0, 8'h00);
    cmp({8'h0, q & 8'h1F}, 16'h000E);
    bus(A_CFG, 1'b1, 8'h10);
    bus(A_ST, 1'b1, 8'h01);
    cmp({14'h0, rx_irq_o, shared_irq_o}, 16'h3);
    bus(A_ST, 1'b1, 8'h00);
    cmp({14'h0, rx_irq_o, shared_irq_o}, 16'h0);
    $display("test slave done");
  endtask
  task automatic t_mono();
    bus(A_CFG, 1'b1, 8'h05);
    bus(A_DL, 1'b1, 8'h11);
    bus(A_DH, 1'b1, 8'h77);
    bus(A_DL, 1'b1, 8'h88);
    bus(A_DH, 1'b1, 8'h22);
    run = 1'b1;
    wait_got(1, 16'h7711);
    run = 1'b0;
    $display("test mono done");
  endtask
  task automatic t_master();
    int   n;
    int   k;
    logic w;
    logic p;
    bus(A_CFG, 1'b1, 8'h03);
    cmp({14'h0, pin_o.sck_oe, pin_o.ws_oe}, 16'h3);
    n = 0;
    k = 0;
    w = pin_o.ws;
    while (pin_o.ws === w && k < 2000) begin
      @(posedge clk_i);
      k++;
    end
    w = pin_o.ws;
    p = pin_o.sck;
    while (pin_o.ws === w && k < 4000) begin
      @(posedge clk_i);
      k++;
      if (pin_o.sck === 1'b1 && p === 1'b0) n++;
      p = pin_o.sck;
    end
    cmp(16'(n), 16'(`IAS_WORDS_RST) + 16'h1);
    $display("test master done");
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    wb_i = '0;
    run = 1'b0;
    m_tx = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_engine();
    t_slave();
    t_mono();
    t_master();
    summarize();
  end
  initial begin
    #1000000;
    errors++;
    summarize();
  end
endmodule // ias_audio_port_tb
